// >>> design/bulk_data_file_control.sv
// File controller moving bulk data between working memory and non-volatile files.
`include "bulk_file_defines.svh"

// Summary of operation
// [RL1] Saving a configuration: host writes the file name, then the create code.
// [RL2] Create copies all working configuration words into the named stored file.
// [RL3] At most four user configuration files exist in storage.
// [RL4] Configuration files take only the four fixed user names; others are refused.
// [RL5] Creating an existing configuration file overwrites it with working values.
// [RL6] Offset shading saves under its fixed name through the shading page.
// [RL7] Gain shading create copies working gain values into its fixed file.
// [RL8] Only one gain shading file exists; create overwrites it.
// [RL9] Activate on the configuration page with an existing file name loads it into working memory.
// [RL10] Activate links the file; every reset reloads the linked file.
// [RL11] The factory file name is accepted by activate like a user file.
// [RL12] Enumerate code starts a walk and shows the first stored name.
// [RL13] Info shows exists, exists and activated, or no more files.
// [RL14] Enumerate-next advances to the following stored file and updates info.
// [RL15] Three separate register pages: configuration, shading and area list.
// [RL16] Each page status reads unavailable, valid, or value out of range.
// [RL17] Control acts on the stored full name; copy finishes before new commands.
module bulk_data_file_control (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic nv_erase,
  input wire logic vol_wr_en,
  input wire logic [1:0] vol_wr_block,
  input wire logic [2:0] vol_wr_addr,
  input wire logic [7:0] vol_wr_data,
  input wire logic [1:0] vol_rd_block,
  input wire logic [2:0] vol_rd_addr,
  output logic [7:0] vol_rd_data,
  output logic copy_busy,
  output logic config_loaded
);
  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam logic [15:0] BASE_CFG = `BASE_CONFIG;
  localparam logic [15:0] BASE_SHD = `BASE_SHADING;
  localparam logic [15:0] BASE_AOI = `BASE_AOI_LIST;

  bulk_file_pkg::byte_t status_ff [3];
  bulk_file_pkg::byte_t info_ff [3];
  bulk_file_pkg::byte_t ctrl_ff [3];
  bulk_file_pkg::name_t name_ff [3];
  bulk_file_pkg::slot_t enum_pos_ff [3];
  logic [7:0] nv_valid_ff;
  bulk_file_pkg::slot_t link_ff;
  bulk_file_pkg::byte_t nv_mem [64];
  bulk_file_pkg::byte_t vol_mem [32];
  bulk_file_pkg::ctl_state_e state_ff;
  bulk_file_pkg::dir_e op_dir_ff;
  bulk_file_pkg::slot_t op_slot_ff;
  logic [1:0] op_block_ff;
  bulk_file_pkg::inst_t op_inst_ff;
  logic [7:0] reg_rdata_ff;
  logic [7:0] vol_rd_data_ff;
  logic copy_busy_ff;
  logic config_loaded_ff;

  logic [10:0] wr_dec;
  logic [10:0] rd_dec;
  logic hit;
  bulk_file_pkg::inst_t hit_inst;
  logic [7:0] ofs;
  logic is_name;
  logic idle;
  logic wr_ctl;
  logic [5:0] rng;
  logic [3:0] search_from;
  logic [3:0] found;
  logic [3:0] nm;
  logic accept_copy;
  logic enum_op;
  logic wr_bad;
  logic load_end;

  copy_if cp ();

  copy_engine u_copy (
    .clk_sys(clk_sys),
    .reset(reset),
    .cp(cp.engine)
  );

  // --------------------------------------------------------------------------
  // Decoding functions
  // --------------------------------------------------------------------------
  // Address to {hit, page, offset}; all pages are 128-byte aligned.
  function automatic logic [10:0] decode_addr(input logic [15:0] a);
    logic [7:0] o;
    o = {1'h0, a[6:0]};
    decode_addr = 11'h0;
    if (a[15:7] == BASE_CFG[15:7]) decode_addr = {1'h1, 2'h0, o};
    else if (a[15:7] == BASE_SHD[15:7]) decode_addr = {1'h1, 2'h1, o};
    else if (a[15:7] == BASE_AOI[15:7]) decode_addr = {1'h1, 2'h2, o};
  endfunction

  // First and last stored slot owned by each page.
  function automatic logic [5:0] slot_range(input bulk_file_pkg::inst_t i);
    unique case (i)
      2'h0: slot_range = {3'h0, `SLOT_FACTORY};
      2'h1: slot_range = {`SLOT_OFFSET, `SLOT_GAIN};
      default: slot_range = {`SLOT_AOI, `SLOT_AOI};
    endcase
  endfunction

  // Fixed name of each stored slot.
  function automatic bulk_file_pkg::name_t slot_name(input bulk_file_pkg::slot_t s);
    unique case (s)
      3'h0: slot_name = `NAME_USER1;
      3'h1: slot_name = `NAME_USER2;
      3'h2: slot_name = `NAME_USER3;
      3'h3: slot_name = `NAME_USER4;
      3'h4: slot_name = `NAME_FACTORY;
      3'h5: slot_name = `NAME_OFFSET;
      3'h6: slot_name = `NAME_GAIN;
      default: slot_name = `NAME_AOI;
    endcase
  endfunction

  // Working memory block that each stored slot belongs to.
  function automatic logic [1:0] slot_block(input bulk_file_pkg::slot_t s);
    if (s <= `SLOT_FACTORY) slot_block = 2'h0;
    else if (s == `SLOT_OFFSET) slot_block = 2'h1;
    else if (s == `SLOT_GAIN) slot_block = 2'h2;
    else slot_block = 2'h3;
  endfunction

  // Name match within a page: {found, slot}; unknown names do not match.
  function automatic logic [3:0] decode_name(input bulk_file_pkg::inst_t i,
                                             input bulk_file_pkg::name_t n);
    logic [5:0] r;
    r = slot_range(i);
    decode_name = 4'h0;
    for (int s = 0; s < 8; s++) begin
      if (!decode_name[3] && s >= r[5:3] && s <= r[2:0] && slot_name(3'(s)) == n) begin
        decode_name = {1'h1, 3'(s)}; // RL4
      end
    end
  endfunction

  // First valid slot at or above from, within lo..hi: {found, slot}.
  function automatic logic [3:0] find_slot(input logic [7:0] v, input logic [3:0] from,
                                           input logic [5:0] r);
    find_slot = 4'h0;
    for (int s = 0; s < 8; s++) begin
      if (!find_slot[3] && s >= from && s >= r[5:3] && s <= r[2:0] && v[s]) begin
        find_slot = {1'h1, 3'(s)};
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  // Writes and reads share one decoder; each page is its own register set.
  assign wr_dec = decode_addr(reg_addr); // RL15
  assign rd_dec = wr_dec;
  assign hit = wr_dec[10];
  assign hit_inst = wr_dec[9:8];
  assign ofs = wr_dec[7:0];
  assign is_name = (ofs >= `OFS_NAME) && (int'(ofs) < int'(`OFS_NAME) + `NAME_BYTES);
  assign idle = (state_ff == bulk_file_pkg::ST_IDLE);
  assign wr_ctl = reg_wr && hit && (ofs == `OFS_CONTROL);
  assign rng = slot_range(hit_inst);
  assign search_from = (reg_wdata == `CODE_ENUM) ? {1'h0, rng[5:3]} :
                       ({1'h0, enum_pos_ff[hit_inst]} + 4'h1); // RL14
  assign found = find_slot(nv_valid_ff, search_from, rng);
  assign nm = decode_name(hit_inst, name_ff[hit_inst]); // RL17

  // Create takes any fixed name of its own page but the factory one; activate needs an existing file.
  assign accept_copy = idle && wr_ctl && nm[3] &&
    ((reg_wdata == `CODE_CREATE && nm[2:0] != `SLOT_FACTORY) || // RL1 RL5 RL6 RL8
     (reg_wdata == `CODE_ACTIVATE && hit_inst == 2'h0 && nv_valid_ff[nm[2:0]])); // RL9 RL11
  assign enum_op = idle && wr_ctl &&
    (reg_wdata == `CODE_ENUM || reg_wdata == `CODE_ENUM_NEXT); // RL12
  // Busy, unknown code or unknown name: refused and flagged.
  assign wr_bad = reg_wr && hit &&
    ((ofs == `OFS_CONTROL && !accept_copy && !enum_op) || (is_name && !idle)); // RL17
  assign load_end = cp.done && (op_dir_ff == bulk_file_pkg::DIR_LOAD);
  assign cp.start = (state_ff == bulk_file_pkg::ST_BOOT) || accept_copy;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Boot load after reset, then idle; a copy holds off all new commands.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= bulk_file_pkg::ST_BOOT;
    end else begin
      unique case (state_ff)
        bulk_file_pkg::ST_BOOT: state_ff <= bulk_file_pkg::ST_COPY; // RL10
        bulk_file_pkg::ST_IDLE: if (accept_copy) state_ff <= bulk_file_pkg::ST_COPY;
        bulk_file_pkg::ST_COPY: if (cp.done) state_ff <= bulk_file_pkg::ST_IDLE; // RL17
      endcase
    end
  end

  // Operation latched at its start: direction, stored slot, working block.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_dir_ff <= bulk_file_pkg::DIR_LOAD;
      op_slot_ff <= `SLOT_FACTORY;
      op_block_ff <= 2'h0;
      op_inst_ff <= 2'h0;
    end else if (state_ff == bulk_file_pkg::ST_BOOT) begin
      op_dir_ff <= bulk_file_pkg::DIR_LOAD;
      op_slot_ff <= link_ff; // RL10
      op_block_ff <= 2'h0;
      op_inst_ff <= 2'h0;
    end else if (accept_copy) begin
      op_dir_ff <= (reg_wdata == `CODE_CREATE) ? bulk_file_pkg::DIR_SAVE :
                   bulk_file_pkg::DIR_LOAD;
      op_slot_ff <= nm[2:0];
      op_block_ff <= slot_block(nm[2:0]); // RL6 RL7
      op_inst_ff <= hit_inst;
    end
  end

  // --------------------------------------------------------------------------
  // Non-volatile storage: contents, valid flags and link survive reset
  // --------------------------------------------------------------------------
  // Storage words: erase writes the factory file; a save step writes one word.
  always_ff @(posedge clk_sys) begin
    if (nv_erase) begin
      for (int k = 0; k < `BLOCK_WORDS; k++) begin
        nv_mem[{`SLOT_FACTORY, 3'(k)}] <= `FACTORY_WORD;
      end
    end else if (cp.step && op_dir_ff == bulk_file_pkg::DIR_SAVE) begin
      nv_mem[{op_slot_ff, cp.idx}] <= vol_mem[{op_block_ff, cp.idx}]; // RL2 RL5 RL8
    end
  end

  // A finished save marks its slot as stored; only eight fixed slots exist.
  always_ff @(posedge clk_sys) begin
    if (nv_erase) begin
      nv_valid_ff <= `NV_VALID_ERASED;
    end else if (cp.done && op_dir_ff == bulk_file_pkg::DIR_SAVE) begin
      nv_valid_ff[op_slot_ff] <= 1'h1; // RL3
    end
  end

  // The link follows each finished configuration load.
  always_ff @(posedge clk_sys) begin
    if (nv_erase) begin
      link_ff <= `SLOT_FACTORY;
    end else if (load_end && op_inst_ff == 2'h0) begin
      link_ff <= op_slot_ff; // RL10
    end
  end

  // --------------------------------------------------------------------------
  // Working memory
  // --------------------------------------------------------------------------
  // Loads take priority; an outside write during a load step is dropped.
  always_ff @(posedge clk_sys) begin
    if (cp.step && op_dir_ff == bulk_file_pkg::DIR_LOAD) begin
      vol_mem[{op_block_ff, cp.idx}] <= nv_mem[{op_slot_ff, cp.idx}]; // RL9
    end else if (vol_wr_en) begin
      vol_mem[{vol_wr_block, vol_wr_addr}] <= vol_wr_data;
    end
  end

  // Working memory read port, one cycle latency.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      vol_rd_data_ff <= 8'h00;
    end else begin
      vol_rd_data_ff <= vol_mem[{vol_rd_block, vol_rd_addr}];
    end
  end

  // --------------------------------------------------------------------------
  // Per-page registers
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_page
    logic sel;
    assign sel = hit && (hit_inst == 2'(i));

    // Status: out of range after a refused write, valid after an accepted one.
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        status_ff[i] <= `STAT_OK;
      end else if (wr_bad && sel) begin
        status_ff[i] <= `STAT_RANGE; // RL16
      end else if (reg_wr && sel && (ofs == `OFS_CONTROL || is_name)) begin
        status_ff[i] <= `STAT_OK; // RL16
      end
    end

    // Control field keeps the last code written.
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        ctrl_ff[i] <= `RST_CTRL;
      end else if (wr_ctl && sel) begin
        ctrl_ff[i] <= reg_wdata;
      end
    end

    // Enumeration result: activated, plain, or end of list.
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        info_ff[i] <= `INFO_NONE;
        enum_pos_ff[i] <= 3'h0;
      end else if (enum_op && sel) begin
        if (!found[3]) begin
          info_ff[i] <= `INFO_NONE; // RL13
        end else if (i == 0 && found[2:0] == link_ff) begin
          info_ff[i] <= `INFO_ACTIVE; // RL13
        end else begin
          info_ff[i] <= `INFO_EXISTS; // RL13
        end
        if (found[3]) enum_pos_ff[i] <= found[2:0]; // RL14
      end
    end

    // Name field: byte writes while idle, or the name shown by enumeration.
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        name_ff[i] <= `RST_NAME;
      end else if (enum_op && sel && found[3]) begin
        name_ff[i] <= slot_name(found[2:0]); // RL12 RL14
      end else if (reg_wr && sel && is_name && idle) begin
        for (int k = 0; k < `NAME_BYTES; k++) begin
          if (int'(ofs) == int'(`OFS_NAME) + k) name_ff[i][159 - 8 * k -: 8] <= reg_wdata;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read port and outputs
  // --------------------------------------------------------------------------
  // Read data stands only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk_sys) begin
    if (reset || !reg_rd || !rd_dec[10]) begin
      reg_rdata_ff <= 8'h00;
    end else if (rd_dec[7:0] == `OFS_STATUS) begin
      reg_rdata_ff <= idle ? status_ff[rd_dec[9:8]] : `STAT_UNAVAIL; // RL16
    end else if (rd_dec[7:0] == `OFS_CONTROL) begin
      reg_rdata_ff <= ctrl_ff[rd_dec[9:8]];
    end else if (rd_dec[7:0] == `OFS_INFO) begin
      reg_rdata_ff <= info_ff[rd_dec[9:8]];
    end else begin
      reg_rdata_ff <= 8'h00;
      for (int k = 0; k < `NAME_BYTES; k++) begin
        if (int'(rd_dec[7:0]) == int'(`OFS_NAME) + k) begin
          reg_rdata_ff <= name_ff[rd_dec[9:8]][159 - 8 * k -: 8];
        end
      end
    end
  end

  // Busy and configuration-loaded flags for the rest of the device.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      copy_busy_ff <= 1'h0;
      config_loaded_ff <= 1'h0;
    end else begin
      copy_busy_ff <= !idle;
      config_loaded_ff <= load_end && op_block_ff == 2'h0; // RL10
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign vol_rd_data = vol_rd_data_ff;
  assign copy_busy = copy_busy_ff;
  assign config_loaded = config_loaded_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence copy_run_s;
    (state_ff == bulk_file_pkg::ST_COPY) [*8] ##1 idle;
  endsequence

  copy_length_a: assert property (accept_copy |=> copy_run_s) // RL17
    else $error("copy did not last eight cycles");
  save_valid_a: assert property ($fell(state_ff == bulk_file_pkg::ST_COPY) &&
    op_dir_ff == bulk_file_pkg::DIR_SAVE |-> nv_valid_ff[op_slot_ff]) // RL2
    else $error("saved slot not marked stored");
  create_name_a: assert property (accept_copy && reg_wdata == `CODE_CREATE
    |-> nm[2:0] != `SLOT_FACTORY && nm[2:0] >= rng[5:3] && nm[2:0] <= rng[2:0]) // RL4
    else $error("create accepted for wrong name");
  link_set_a: assert property (load_end && op_inst_ff == 2'h0
    |=> link_ff == $past(op_slot_ff)) // RL10
    else $error("activate did not record link");
  boot_load_a: assert property ($fell(reset) |-> state_ff == bulk_file_pkg::ST_BOOT
    ##1 (op_slot_ff == link_ff && op_dir_ff == bulk_file_pkg::DIR_LOAD)) // RL10
    else $error("linked file not loaded after reset");
  factory_act_a: assert property (wr_ctl && idle && hit_inst == 2'h0 &&
    reg_wdata == `CODE_ACTIVATE && name_ff[0] == `NAME_FACTORY &&
    nv_valid_ff[`SLOT_FACTORY] |-> accept_copy) // RL11
    else $error("factory activate refused");
  info_codes_a: assert property (info_ff[0] == `INFO_EXISTS ||
    info_ff[0] == `INFO_NONE || info_ff[0] == `INFO_ACTIVE) // RL13
    else $error("illegal info code");
  enum_end_a: assert property (enum_op && !found[3]
    |=> info_ff[$past(hit_inst)] == `INFO_NONE) // RL14
    else $error("end of enumeration not reported");
  status_range_a: assert property (wr_bad |=>
    status_ff[$past(hit_inst)] == `STAT_RANGE) // RL16
    else $error("refused write not flagged");
  load_done_a: assert property (load_end && op_block_ff == 2'h0 |=> config_loaded) // RL9
    else $error("configuration load not signalled");
endmodule // bulk_data_file_control

// >>> common/bulk_file_defines.svh
// Constants for the bulk data file control block: offsets, codes, resets, names.
`ifndef BULK_FILE_DEFINES_SVH
`define BULK_FILE_DEFINES_SVH
// ----------------------------------------------------------------------------
// Register pages and field offsets
// ----------------------------------------------------------------------------
`define BASE_CONFIG 16'h2800
`define BASE_SHADING 16'h2A80
`define BASE_AOI_LIST 16'h2B00
`define OFS_STATUS 8'h00
`define OFS_CONTROL 8'h01
`define OFS_INFO 8'h02
`define OFS_NAME 8'h03
`define NAME_BYTES 20
// ----------------------------------------------------------------------------
// Control codes, status codes and info codes
// ----------------------------------------------------------------------------
`define CODE_ENUM 8'h00
`define CODE_ENUM_NEXT 8'h01
`define CODE_ACTIVATE 8'h05
`define CODE_CREATE 8'h06
`define STAT_UNAVAIL 8'h00
`define STAT_OK 8'h01
`define STAT_RANGE 8'h80
`define INFO_EXISTS 8'h00
`define INFO_NONE 8'h01
`define INFO_ACTIVE 8'h04
// ----------------------------------------------------------------------------
// File slots, block size and reset values
// ----------------------------------------------------------------------------
`define BLOCK_WORDS 8
`define LAST_WORD 3'h7
`define SLOT_FACTORY 3'h4
`define SLOT_OFFSET 3'h5
`define SLOT_GAIN 3'h6
`define SLOT_AOI 3'h7
`define NV_VALID_ERASED 8'h10
`define FACTORY_WORD 8'hA5
`define RST_CTRL 8'h00
`define RST_NAME 160'h0
// ----------------------------------------------------------------------------
// Fixed file names, left-aligned and zero-padded to 20 bytes
// ----------------------------------------------------------------------------
`define NAME_USER1 {"usercfg01", 88'h0}
`define NAME_USER2 {"usercfg02", 88'h0}
`define NAME_USER3 {"usercfg03", 88'h0}
`define NAME_USER4 {"usercfg04", 88'h0}
`define NAME_FACTORY {"factorycfg", 80'h0}
`define NAME_OFFSET {"offsetshading", 56'h0}
`define NAME_GAIN {"gainshading", 72'h0}
`define NAME_AOI {"aoilist", 104'h0}
`endif

// >>> common/bulk_file_pkg.sv
// Types shared by the bulk data file control block and its copy engine.
package bulk_file_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [159:0] name_t;
  typedef logic [2:0] slot_t;
  typedef logic [1:0] inst_t;
  typedef logic [2:0] word_idx_t;
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_COPY} ctl_state_e;
  typedef enum logic {DIR_SAVE, DIR_LOAD} dir_e;
endpackage : bulk_file_pkg

// >>> common/copy_if.sv
// Handshake between the file controller and its block copy engine.
interface copy_if;
  logic start;
  logic step;
  logic done;
  bulk_file_pkg::word_idx_t idx;
  modport engine (input start, output step, output done, output idx);
  modport user (output start, input step, input done, input idx);
endinterface : copy_if

// >>> design/copy_engine.sv
// Word sequencer that walks one data block, one word per cycle.
`include "bulk_file_defines.svh"

module copy_engine (
  input wire logic clk_sys,
  input wire logic reset,
  copy_if.engine cp
);
  logic run_ff;
  bulk_file_pkg::word_idx_t idx_ff;

  // Run flag: raised by a start, dropped after the last word.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_ff <= 1'h0;
    end else if (cp.start) begin
      run_ff <= 1'h1;
    end else if (run_ff && idx_ff == `LAST_WORD) begin
      run_ff <= 1'h0;
    end
  end

  // Word index restarts at zero on every start.
  always_ff @(posedge clk_sys) begin
    if (reset || cp.start) begin
      idx_ff <= 3'h0;
    end else if (run_ff) begin
      idx_ff <= idx_ff + 3'h1;
    end
  end

  // One step per running cycle; done marks the final word.
  assign cp.step = run_ff;
  assign cp.idx = idx_ff;
  assign cp.done = run_ff && (idx_ff == `LAST_WORD);
endmodule // copy_engine

// >>> verification/host_model.sv
// Host model driving register writes and reads on the plain register port.
module host_model (
  input wire logic clk_sys,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus is idle at time zero.
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end
  // A write is one cycle; released data lines show the inverse value.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    reg_wdata <= ~d;
  endtask
  // A read is one cycle; the data is taken in the following cycle only.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  // The whole name goes out before any control code follows.
  task automatic wname(input logic [15:0] pg, input bulk_file_pkg::name_t n);
    for (int i = 0; i < 20; i++) begin
      wr(pg + 16'h3 + 16'(i), n[159 - 8 * i -: 8]);
    end
  endtask
endmodule // host_model

// >>> verification/bulk_data_file_control_test.sv
// Self-checking bench for the bulk data file controller.
`include "bulk_file_defines.svh"
module bulk_data_file_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] pg; bulk_file_pkg::name_t nm; logic [7:0] code;
    logic [7:0] st;} row_s;
  localparam logic [15:0] cfg_pg = `BASE_CONFIG;
  localparam logic [15:0] shd_pg = `BASE_SHADING;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic nv_erase = 1'h1;
  logic vol_wr_en = 1'h0;
  logic [2:0] vol_wr_addr = 3'h0;
  logic [2:0] vol_rd_addr = 3'h0;
  logic [7:0] vol_wr_data = 8'h00;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, vol_rd_data, got;
  logic reg_wr, reg_rd, copy_busy, config_loaded;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  row_s rows[10];
  // The clock toggles every half period; a cycle ceiling cuts a hang short.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  // The host model and the design under test.
  host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  bulk_data_file_control dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nv_erase(nv_erase), .vol_wr_en(vol_wr_en), .vol_wr_block(2'h0),
    .vol_wr_addr(vol_wr_addr), .vol_wr_data(vol_wr_data), .vol_rd_block(2'h0),
    .vol_rd_addr(vol_rd_addr), .vol_rd_data(vol_rd_data), .copy_busy(copy_busy),
    .config_loaded(config_loaded));
  // Compares one byte and reports a mismatch at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds reset for ten cycles, then lets the boot load finish.
  task automatic boot();
    @(posedge clk_sys);
    reset <= 1'h1;
    repeat (10) @(posedge clk_sys);
    reset <= 1'h0;
    nv_erase <= 1'h0;
    repeat (12) @(posedge clk_sys);
  endtask
  // Writes eight working configuration words counting up from v.
  task automatic fill(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      vol_wr_en <= 1'h1;
      vol_wr_addr <= 3'(i);
      vol_wr_data <= v + 8'(i);
    end
    @(posedge clk_sys);
    vol_wr_en <= 1'h0;
  endtask
  // Reads back the working configuration words, expecting v plus s per word.
  task automatic vchk(input logic [7:0] v, input logic [7:0] s);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      vol_rd_addr <= 3'(i);
      @(posedge clk_sys);
      #1 chk("word", v + s * 8'(i), vol_rd_data);
    end
  endtask
  // Sends name and code, waits out the copy, then checks the page status.
  task automatic op(input row_s r);
    host.wname(r.pg, r.nm);
    host.wr(r.pg + 16'h1, r.code);
    repeat (8) @(posedge clk_sys);
    #1 chk("busy loaded", {6'h0, r.st == `STAT_OK,
      r.st == `STAT_OK && r.code == `CODE_ACTIVATE}, {6'h0, copy_busy, config_loaded});
    repeat (2) @(posedge clk_sys);
    host.rd(r.pg, got);
    chk("status", r.st, got);
  endtask
  // Checks the presented name and info during a walk of the files.
  task automatic nchk(input bulk_file_pkg::name_t n, input logic [7:0] info);
    for (int i = 0; i < 20; i++) begin
      host.rd(cfg_pg + 16'h3 + 16'(i), got);
      chk("name", n[159 - 8 * i -: 8], got);
    end
    host.rd(cfg_pg + 16'h2, got);
    chk("info", info, got);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Table cases first, then the hand-written ones.
  initial begin
    rows[0] = '{cfg_pg, `NAME_USER1, `CODE_CREATE, `STAT_OK};
    rows[1] = '{cfg_pg, `NAME_USER2, `CODE_CREATE, `STAT_OK};
    rows[2] = '{cfg_pg, `NAME_FACTORY, `CODE_CREATE, `STAT_RANGE};
    rows[3] = '{cfg_pg, `NAME_GAIN, `CODE_CREATE, `STAT_RANGE};
    rows[4] = '{shd_pg, `NAME_OFFSET, `CODE_CREATE, `STAT_OK};
    rows[5] = '{shd_pg, `NAME_GAIN, `CODE_CREATE, `STAT_OK};
    rows[6] = '{shd_pg, `NAME_GAIN, `CODE_CREATE, `STAT_OK};
    rows[7] = '{`BASE_AOI_LIST, `NAME_AOI, `CODE_CREATE, `STAT_OK};
    rows[8] = '{cfg_pg, `NAME_USER1, 8'h02, `STAT_RANGE};
    rows[9] = '{cfg_pg, `NAME_USER3, `CODE_ACTIVATE, `STAT_RANGE};
    boot();
    vchk(`FACTORY_WORD, 8'h00);
    fill(8'h10);
    foreach (rows[i]) begin
      op(rows[i]);
      $display("row %0d done", i);
    end
    // A second create overwrites; activate loads the stored words.
    fill(8'h40);
    op(row_s'{cfg_pg, `NAME_USER1, `CODE_CREATE, `STAT_OK});
    fill(8'h70);
    op(row_s'{cfg_pg, `NAME_USER1, `CODE_ACTIVATE, `STAT_OK});
    vchk(8'h40, 8'h01);
    $display("overwrite and activate done");
    // Walk the stored configuration files to the end.
    host.wr(cfg_pg + 16'h1, `CODE_ENUM);
    nchk(`NAME_USER1, `INFO_ACTIVE);
    host.wr(cfg_pg + 16'h1, `CODE_ENUM_NEXT);
    nchk(`NAME_USER2, `INFO_EXISTS);
    host.wr(cfg_pg + 16'h1, `CODE_ENUM_NEXT);
    nchk(`NAME_FACTORY, `INFO_EXISTS);
    host.wr(cfg_pg + 16'h1, `CODE_ENUM_NEXT);
    host.rd(cfg_pg + 16'h2, got);
    chk("info", `INFO_NONE, got);
    host.rd(cfg_pg + 16'h1, got);
    chk("control", `CODE_ENUM_NEXT, got);
    $display("walk done");
    // A reset reloads the linked file over scrambled working words.
    fill(8'h00);
    boot();
    vchk(8'h40, 8'h01);
    op(row_s'{cfg_pg, `NAME_FACTORY, `CODE_ACTIVATE, `STAT_OK});
    vchk(`FACTORY_WORD, 8'h00);
    $display("reload and factory done");
    // A name write during a copy is ignored.
    host.wr(cfg_pg + 16'h1, `CODE_ACTIVATE);
    host.wr(cfg_pg + 16'h3, 8'h41);
    host.rd(cfg_pg, got);
    chk("busy status", `STAT_UNAVAIL, got);
    repeat (10) @(posedge clk_sys);
    host.rd(cfg_pg + 16'h3, got);
    chk("name", 8'h66, got);
    $display("busy refusal done");
    report_and_stop();
  end
endmodule // bulk_data_file_control_test
